// ===== logic/fts_ctrl.sv
// Tach mode and spin-up control top with its byte register port.
// Assumes lock, start, PWM and spin-up timing come from same-clock logic.
`timescale 1ns/100ps
module fts_ctrl
   import fts_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic cfg_lock,
   input wire logic cfg_start,
   input wire logic pwm_high_range,
   input wire logic [2:0] pwm_freq_sel,
   input wire logic [fts_pkg::FTS_NUM_PWM-1:0] pwm_in,
   input wire logic fan_speed_in1,
   input wire logic fan_speed_in2,
   input wire logic fan_speed_in3,
   input wire logic fan_speed_in4,
   output logic fan_drive_out1,
   output logic fan_drive_out2,
   output logic fan_drive_out3,
   output logic [fts_pkg::FTS_NUM_TACH-1:0][15:0] tach_reading,
   input wire logic [fts_pkg::FTS_NUM_TACH-1:0][15:0] tach_min,
   input wire logic [fts_pkg::FTS_NUM_PWM-1:0] spinup_busy,
   input wire logic [fts_pkg::FTS_NUM_PWM-1:0] spinup_time_up,
   output logic [fts_pkg::FTS_NUM_PWM-1:0] spinup_end,
   input wire logic [fts_pkg::FTS_XOR_PINS-1:0] xor_pins,
   output logic xor_test_mode,
   output logic xor_tree_out
);
   import fts_pkg::*;

   // Register decode used by the write path and the checks; reads decode by case with a zero default
   function automatic logic fts_defined(input logic [7:0] a);
      return (a == FTS_ADDR_TEST) || (a == FTS_ADDR_TACH_MODE) || (a == FTS_ADDR_SPINUP);
   endfunction

   function automatic int fts_drive_of(input int t);
      return (t > 2) ? 2 : t;
   endfunction

   // Register state
   logic [FTS_MODE_W-1:0] mode_q, mode_d;
   logic [FTS_SPINUP_W-1:0] spin_q, spin_d;
   logic xen_q, xen_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      mode_d = mode_q;
      spin_d = spin_q;
      xen_d = xen_q;
      rdata_d = rdata_q;
      if (reg_wr && fts_defined(reg_addr)) begin
         unique case (reg_addr)
            FTS_ADDR_TACH_MODE: mode_d = reg_wdata[FTS_MODE_W-1:0];
            FTS_ADDR_SPINUP: if (!cfg_lock) spin_d = reg_wdata[FTS_SPINUP_W-1:0];
            FTS_ADDR_TEST: if (!cfg_lock) xen_d = reg_wdata[FTS_XEN_BIT];
            default: mode_d = mode_q;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            FTS_ADDR_TACH_MODE: rdata_d = {2'b00, mode_q};
            FTS_ADDR_SPINUP: rdata_d = {5'b00000, spin_q};
            FTS_ADDR_TEST: rdata_d = {7'b0000000, xen_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= FTS_TACH_MODE_RST;
         spin_q <= FTS_SPINUP_RST;
         xen_q <= FTS_TEST_RST[FTS_XEN_BIT];
         rdata_q <= 8'h00;
      end else if (ce) begin
         mode_q <= mode_d;
         spin_q <= spin_d;
         xen_q <= xen_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // Effective settings: defaults until start, mode 0 in high range
   logic [FTS_MODE_W-1:0] mode_eff;
   logic [FTS_SPINUP_W-1:0] spin_eff;
   assign mode_eff = pwm_high_range ? FTS_TACH_MODE_RST : (cfg_start ? mode_q : FTS_TACH_MODE_RST);
   assign spin_eff = cfg_start ? spin_q : FTS_SPINUP_RST;

   // Shared measurement tick
   logic [15:0] tick_cnt_q, tick_cnt_d;
   logic tick_q, tick_d;
   always_comb begin
      tick_d = (tick_cnt_q == 16'(FTS_TICK_CYC - 1));
      tick_cnt_d = tick_d ? 16'h0000 : tick_cnt_q + 16'h0001;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (ce) begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // Tach channels
   logic [FTS_NUM_TACH-1:0] tach_pin;
   logic [FTS_NUM_TACH-1:0] stretch;
   logic [FTS_NUM_PWM-1:0] drive_q, drive_d;
   fts_mode_t tmode [FTS_NUM_TACH];
   assign tach_pin = {fan_speed_in4, fan_speed_in3, fan_speed_in2, fan_speed_in1};
   assign tmode[0] = fts_mode_t'(mode_eff[FTS_MODE_IN1_LSB +: 2]);
   assign tmode[1] = fts_mode_t'(mode_eff[FTS_MODE_IN2_LSB +: 2]);
   assign tmode[2] = fts_mode_t'(mode_eff[FTS_MODE_IN34_LSB +: 2]);
   assign tmode[3] = fts_mode_t'(mode_eff[FTS_MODE_IN34_LSB +: 2]);

   fts_tach_if tif [FTS_NUM_TACH] ();

   genvar gi;
   generate
      for (gi = 0; gi < FTS_NUM_TACH; gi++) begin : g_tach
         assign tif[gi].mode = tmode[gi];
         assign tif[gi].tick = tick_q;
         assign tif[gi].limit = fts_limit(tmode[gi], pwm_freq_sel);
         assign tif[gi].pin = tach_pin[gi];
         // Fans 3 and 4 share the third drive
         assign tif[gi].pwm_raw = pwm_in[fts_drive_of(gi)];
         assign tif[gi].drive_hi = drive_q[fts_drive_of(gi)];
         assign stretch[gi] = tif[gi].stretch;
         assign tach_reading[gi] = tif[gi].reading;
         fts_tach_meas u_meas (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .ch(tif[gi])
         );
      end
   endgenerate

   always_comb begin
      drive_d[0] = pwm_in[0] | stretch[0];
      drive_d[1] = pwm_in[1] | stretch[1];
      drive_d[2] = pwm_in[2] | stretch[2] | stretch[3];
   end

   // Spin-up termination
   logic [FTS_NUM_PWM-1:0] below, end_q, end_d;
   always_comb begin
      below[0] = tach_reading[0] < tach_min[0];
      below[1] = tach_reading[1] < tach_min[1];
      below[2] = (tach_reading[2] < tach_min[2]) || (tach_reading[3] < tach_min[3]);
      for (int j = 0; j < FTS_NUM_PWM; j++) begin
         end_d[j] = spinup_busy[j] && !end_q[j] && (spinup_time_up[j] || (spin_eff[j] && below[j]));
      end
   end

   // XOR tree over non-bus pins
   logic [FTS_XOR_PINS-1:0] xs1_q, xs2_q;
   logic xor_q, xor_d;
   always_comb begin
      xor_d = xen_q ? ^xs2_q : 1'b0;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_q <= '0;
         end_q <= '0;
         xs1_q <= '0;
         xs2_q <= '0;
         xor_q <= 1'b0;
      end else if (ce) begin
         drive_q <= drive_d;
         end_q <= end_d;
         xs1_q <= xor_pins;
         xs2_q <= xs1_q;
         xor_q <= xor_d;
      end
   end

   assign fan_drive_out1 = drive_q[0];
   assign fan_drive_out2 = drive_q[1];
   assign fan_drive_out3 = drive_q[2];
   assign spinup_end = end_q;
   assign xor_test_mode = xen_q;
   assign xor_tree_out = xor_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_spin_wr_locked;
      ce && reg_wr && reg_addr == FTS_ADDR_SPINUP && cfg_lock;
   endsequence

   AST_LOCK_SPINUP: assert property (s_spin_wr_locked |=> $stable(spin_q))
      else $error("locked spin-up register changed");
   AST_MODE_WR_LOCK: assert property (ce && reg_wr && reg_addr == FTS_ADDR_TACH_MODE |=>
      mode_q == $past(reg_wdata[5:0]))
      else $error("tach mode write lost");
   AST_UNDEF_READ: assert property (ce && reg_rd && !fts_defined(reg_addr) |=> reg_rdata == 8'h00)
      else $error("undefined read not zero");
   AST_UNDEF_WRITE: assert property (ce && reg_wr && !fts_defined(reg_addr) |=>
      $stable(mode_q) && $stable(spin_q) && $stable(xen_q))
      else $error("undefined write changed state");
   AST_START_DEFAULT: assert property (!cfg_start && ce && spinup_busy[0] && !end_q[0] && below[0] |=>
      spinup_end[0])
      else $error("default early exit not used before start");
   AST_XEN_ENTER: assert property (ce && reg_wr && reg_addr == FTS_ADDR_TEST && !cfg_lock && reg_wdata[0] |=>
      xor_test_mode)
      else $error("test mode not entered");
   AST_NO_EARLY: assert property (ce && spinup_busy[0] && !spinup_time_up[0] && !spin_eff[0] |=>
      !spinup_end[0])
      else $error("spin-up ended early");
   AST_EARLY_EXIT: assert property (ce && spinup_busy[1] && spin_eff[1] && below[1] && !end_q[1] |=>
      spinup_end[1])
      else $error("early spin-up exit missed");
   AST_HIGH_RANGE: assert property (pwm_high_range |-> mode_eff == 6'h00)
      else $error("compensating mode in high range");

endmodule

// ===== logic/fts_pkg.sv
// Constants, register map and types for the fan tach mode and spin-up block.
// Assumes a 50 MHz system clock and a byte-wide register access port.
package fts_pkg;

   // Register offsets
   localparam logic [7:0] FTS_ADDR_TEST = 8'h6F;
   localparam logic [7:0] FTS_ADDR_TACH_MODE = 8'h74;
   localparam logic [7:0] FTS_ADDR_SPINUP = 8'h75;

   // Values after reset
   localparam logic [7:0] FTS_TEST_RST = 8'h00;
   localparam logic [5:0] FTS_TACH_MODE_RST = 6'h00;
   localparam logic [2:0] FTS_SPINUP_RST = 3'h7;

   // Field positions
   localparam int FTS_XEN_BIT = 0;
   localparam int FTS_MODE_IN1_LSB = 0;
   localparam int FTS_MODE_IN2_LSB = 2;
   localparam int FTS_MODE_IN34_LSB = 4;
   localparam int FTS_MODE_W = 6;
   localparam int FTS_SPINUP_W = 3;

   // Timing
   localparam int unsigned FTS_CLK_NS = 20;
   localparam int unsigned FTS_TICK_NS = 10000;
   localparam int unsigned FTS_TICK_CYC = (FTS_TICK_NS + FTS_CLK_NS - 1) / FTS_CLK_NS;
   localparam int unsigned FTS_TICK_HZ = 1000000000 / FTS_TICK_NS;
   localparam int unsigned FTS_STRETCH_US = 2000;
   localparam int unsigned FTS_STRETCH_TICKS = (FTS_STRETCH_US * 1000) / FTS_TICK_NS;
   localparam int unsigned FTS_PULSES_PER_REV = 2;
   localparam int unsigned FTS_TICKS_PER_MIN = 60 * FTS_TICK_HZ;

   localparam logic [15:0] FTS_UNDER_RANGE = 16'hFFFF;
   localparam int FTS_NUM_TACH = 4;
   localparam int FTS_NUM_PWM = 3;
   localparam int FTS_XOR_PINS = 12;

   // Minimum detectable RPM by PWM frequency select
   localparam int unsigned FTS_RPM_STD [0:7] = '{841, 1262, 1944, 2523, 3205, 3953, 5156, 7906};
   localparam int unsigned FTS_RPM_EXT [0:7] = '{210, 315, 420, 420, 420, 420, 420, 420};

   typedef enum logic [1:0] {
      FTS_MODE_PLAIN,
      FTS_MODE_FLAG,
      FTS_MODE_ACCURATE,
      FTS_MODE_GENTLE
   } fts_mode_t;

   // Tick count per revolution at the minimum RPM
   function automatic logic [15:0] fts_limit(input fts_mode_t m, input logic [2:0] sel);
      int unsigned rpm;
      rpm = (m == FTS_MODE_PLAIN || m == FTS_MODE_FLAG) ? FTS_RPM_STD[sel] : FTS_RPM_EXT[sel];
      return 16'(FTS_TICKS_PER_MIN / rpm);
   endfunction

endpackage

// ===== logic/fts_tach_if.sv
// Carrier between the control top and one tach measurement channel.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface fts_tach_if;
   import fts_pkg::*;
   fts_mode_t mode;
   logic tick;
   logic [15:0] limit;
   logic pin;
   logic pwm_raw;
   logic drive_hi;
   logic stretch;
   logic [15:0] reading;

   modport ctl (output mode, output tick, output limit, output pin, output pwm_raw, output drive_hi,
                input stretch, input reading);
   modport meas (input mode, input tick, input limit, input pin, input pwm_raw, input drive_hi,
                 output stretch, output reading);
endinterface

// ===== logic/fts_tach_meas.sv
// One tach channel: pin synchroniser, revolution timer and PWM stretch.
// Assumes a shared tick strobe and drive level from the control top.
`timescale 1ns/100ps
module fts_tach_meas
   import fts_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   fts_tach_if.meas ch
);
   logic sync1_q, sync2_q, prev_q, sync1_d, sync2_d, prev_d;
   logic [15:0] cnt_q, cnt_d, reading_q, reading_d;
   logic [1:0] pcnt_q, pcnt_d;
   logic stretch_q, stretch_d, pwm_prev_q, pwm_prev_d;
   logic [15:0] scnt_q, scnt_d;
   logic rise, edge_ok, over;

   assign ch.reading = reading_q;
   assign ch.stretch = stretch_q;

   always_comb begin
      sync1_d = ch.pin;
      sync2_d = sync1_q;
      prev_d = sync2_q;
      rise = sync2_q & ~prev_q;
      // Compensating modes only trust edges while the fan is powered
      edge_ok = rise && (ch.mode == FTS_MODE_PLAIN || ch.mode == FTS_MODE_FLAG || ch.drive_hi);
      over = (ch.mode != FTS_MODE_PLAIN) && (cnt_q >= ch.limit);
      cnt_d = ch.tick ? cnt_q + 16'h0001 : cnt_q;
      pcnt_d = pcnt_q;
      reading_d = reading_q;
      if (over) begin
         reading_d = FTS_UNDER_RANGE;
         cnt_d = 16'h0000;
         pcnt_d = 2'h0;
      end else if (edge_ok) begin
         if (pcnt_q == 2'(FTS_PULSES_PER_REV - 1)) begin
            reading_d = cnt_q;
            cnt_d = 16'h0000;
            pcnt_d = 2'h0;
         end else begin
            pcnt_d = pcnt_q + 2'h1;
         end
      end
      // Accurate mode holds the drive on after PWM falls until a tach edge or FTS_STRETCH_TICKS ticks
      pwm_prev_d = ch.pwm_raw;
      stretch_d = stretch_q;
      scnt_d = (stretch_q && ch.tick) ? scnt_q + 16'h0001 : scnt_q;
      // A PWM fall in the cycle of a tach edge still starts a stretch
      if (ch.mode != FTS_MODE_ACCURATE || scnt_q >= 16'(FTS_STRETCH_TICKS)) begin
         stretch_d = 1'b0;
         scnt_d = 16'h0000;
      end else if (pwm_prev_q && !ch.pwm_raw) begin
         stretch_d = 1'b1;
         scnt_d = 16'h0000;
      end else if (rise) begin
         stretch_d = 1'b0;
         scnt_d = 16'h0000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         // Idle pin level is high, so no false edge after reset
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q <= 1'b1;
         cnt_q <= 16'h0000;
         pcnt_q <= 2'h0;
         reading_q <= 16'h0000;
         stretch_q <= 1'b0;
         pwm_prev_q <= 1'b0;
         scnt_q <= 16'h0000;
      end else if (ce) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q <= prev_d;
         cnt_q <= cnt_d;
         pcnt_q <= pcnt_d;
         reading_q <= reading_d;
         stretch_q <= stretch_d;
         pwm_prev_q <= pwm_prev_d;
         scnt_q <= scnt_d;
      end
   end

   AST_UNDER_RANGE: assert property (@(posedge clk) disable iff (rst)
      ce && ch.mode != FTS_MODE_PLAIN && cnt_q >= ch.limit |=> reading_q == FTS_UNDER_RANGE)
      else $error("under-range reading not flagged");

   AST_STRETCH_MODE: assert property (@(posedge clk) disable iff (rst)
      ce && ch.mode != FTS_MODE_ACCURATE |=> !stretch_q)
      else $error("drive stretched outside accurate mode");

endmodule

// ===== tb/fts_fan_model.sv
// Behavioural PC fans with tach outputs, one per tach input.
// Assumes fans 1 and 2 are powered by their matching drive outputs and fans 3 and 4 share the third.
`timescale 1ns/100ps
module fts_fan_model #(
   parameter int HALF_NS = 50000
) (
   input wire logic en,
   input wire logic [2:0] drive,
   output logic [3:0] tach
);
   initial begin
      tach = 4'hF;
      forever begin
         #(HALF_NS);
         for (int j = 0; j < 4; j++) begin
            // Two pulses per turn, only while powered by its own drive
            if (en && drive[(j > 2) ? 2 : j]) begin
               tach[j] = ~tach[j];
            end else if (!en) begin
               // Open collector with pull-up while stopped
               tach[j] = 1'b1;
            end
         end
      end
   end
endmodule

// ===== tb/fts_ctrl_bench.sv
// Self-checking bench for the tach mode and spin-up control top.
// Assumes the fan model file is compiled first.
`timescale 1ns/100ps
module fts_ctrl_bench;
   import fts_pkg::*;
   logic clk, rst, reg_wr, reg_rd, cfg_lock, cfg_start, fan_en, hi_range;
   logic [2:0] freq_sel;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [2:0] pwm_in, spinup_busy, spinup_time_up, spinup_end, seen, drv;
   logic [3:0] tach;
   logic [3:0][15:0] tach_reading, tach_min;
   logic [11:0] xor_pins;
   logic xor_test_mode, xor_tree_out;
   int error_cnt, comparisons;

   fts_ctrl fts_ctrl_i (.clk(clk), .rst(rst), .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cfg_lock(cfg_lock),
      .cfg_start(cfg_start), .pwm_high_range(hi_range), .pwm_freq_sel(freq_sel), .pwm_in(pwm_in),
      .fan_speed_in1(tach[0]), .fan_speed_in2(tach[1]), .fan_speed_in3(tach[2]),
      .fan_speed_in4(tach[3]), .fan_drive_out1(drv[0]), .fan_drive_out2(drv[1]),
      .fan_drive_out3(drv[2]), .tach_reading(tach_reading), .tach_min(tach_min),
      .spinup_busy(spinup_busy), .spinup_time_up(spinup_time_up), .spinup_end(spinup_end),
      .xor_pins(xor_pins), .xor_test_mode(xor_test_mode), .xor_tree_out(xor_tree_out));

   fts_fan_model #(.HALF_NS(50000)) fts_fan_model_i (.en(fan_en), .drive(drv), .tach(tach));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1 reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   task automatic reg_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      reg_read(a, rd);
      chk(what, {8'h00, exp}, {8'h00, rd});
   endtask

   task automatic watch_end(input int n);
      seen = 3'h0;
      repeat (n) begin
         @(posedge clk);
         #1 seen = seen | spinup_end;
      end
   endtask

   task automatic t_reset();
      reg_chk("tach mode reset", FTS_ADDR_TACH_MODE, 8'h00);
      reg_chk("spinup reset", FTS_ADDR_SPINUP, 8'h07);
      reg_chk("test reset", FTS_ADDR_TEST, 8'h00);
      $display("Test reset done");
   endtask

   task automatic t_fields();
      reg_write(FTS_ADDR_SPINUP, 8'hFA);
      reg_chk("spinup reserved", FTS_ADDR_SPINUP, 8'h02);
      reg_write(FTS_ADDR_TACH_MODE, 8'hFF);
      reg_chk("tach mode reserved", FTS_ADDR_TACH_MODE, 8'h3F);
      reg_write(8'h50, 8'hFF);
      reg_write(8'h76, 8'hFF);
      reg_chk("undefined read", 8'h50, 8'h00);
      reg_chk("undefined read high", 8'h76, 8'h00);
      reg_chk("spinup after stray write", FTS_ADDR_SPINUP, 8'h02);
      reg_chk("mode after stray write", FTS_ADDR_TACH_MODE, 8'h3F);
      $display("Test fields done");
   endtask

   task automatic t_xor();
      reg_write(FTS_ADDR_TEST, 8'h01);
      xor_pins = 12'hA53;
      repeat (6) @(posedge clk);
      #1 chk("xor mode", 16'h0001, {15'h0, xor_test_mode});
      chk("xor even", 16'h0000, {15'h0, xor_tree_out});
      xor_pins = 12'hA52;
      repeat (6) @(posedge clk);
      #1 chk("xor odd", 16'h0001, {15'h0, xor_tree_out});
      reg_write(FTS_ADDR_TEST, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk("xor off", 16'h0000, {15'h0, xor_test_mode});
      $display("Test xor done");
   endtask

   task automatic t_spinup();
      cfg_start = 1'b1;
      tach_min = {4{16'hFFFF}};
      reg_write(FTS_ADDR_SPINUP, 8'h06);
      spinup_busy = 3'h7;
      watch_end(10);
      chk("early exit ends", 16'h0006, {13'h0, seen});
      spinup_time_up = 3'h1;
      watch_end(10);
      chk("time elapsed ends", 16'h0001, {13'h0, seen & 3'h1});
      spinup_busy = 3'h0;
      spinup_time_up = 3'h0;
      cfg_start = 1'b0;
      repeat (3) @(posedge clk);
      #1 spinup_busy = 3'h1;
      watch_end(10);
      chk("start clear defaults", 16'h0001, {13'h0, seen});
      spinup_busy = 3'h0;
      cfg_start = 1'b1;
      $display("Test spinup done");
   endtask

   task automatic t_lock();
      cfg_lock = 1'b1;
      reg_write(FTS_ADDR_SPINUP, 8'h01);
      reg_chk("spinup locked", FTS_ADDR_SPINUP, 8'h06);
      reg_write(FTS_ADDR_TACH_MODE, 8'h15);
      reg_chk("mode writable locked", FTS_ADDR_TACH_MODE, 8'h15);
      cfg_lock = 1'b0;
      reg_chk("mode kept at unlock", FTS_ADDR_TACH_MODE, 8'h15);
      $display("Test lock done");
   endtask

   task automatic t_tach();
      int n;
      logic ok;
      reg_write(FTS_ADDR_TACH_MODE, 8'h39);
      pwm_in = 3'h7;
      fan_en = 1'b1;
      ok = 1'b0;
      n = 0;
      while (!ok && n < 80000) begin
         @(posedge clk);
         #1 n++;
         ok = 1'b1;
         for (int j = 0; j < 4; j++) begin
            if (!(tach_reading[j] >= 16'd19 && tach_reading[j] <= 16'd21)) begin
               ok = 1'b0;
            end
         end
      end
      chk("drive follows pwm", 16'h0007, {13'h0, drv});
      // Turn of 4 x 50 us at 10 us ticks gives 20
      chk("readings in range", 16'h0001, {15'h0, ok});
      if (!ok) begin
         summarize();
      end
      $display("Test tach done");
   endtask

   task automatic t_range();
      logic ok;
      hi_range = 1'b1;
      freq_sel = 3'h7;
      repeat (12000) @(posedge clk);
      #1 ok = 1'b1;
      for (int j = 0; j < 4; j++) begin
         if (!(tach_reading[j] >= 16'd19 && tach_reading[j] <= 16'd21)) begin
            ok = 1'b0;
         end
      end
      chk("high range readings", 16'h0001, {15'h0, ok});
      hi_range = 1'b0;
      freq_sel = 3'h0;
      $display("Test range done");
   endtask

   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, cfg_lock, cfg_start, fan_en, hi_range} = 6'h00;
      freq_sel = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      pwm_in = 3'h0;
      spinup_busy = 3'h0;
      spinup_time_up = 3'h0;
      tach_min = {4{16'h0000}};
      xor_pins = 12'h000;
      error_cnt = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      t_reset();
      t_fields();
      t_xor();
      t_spinup();
      t_lock();
      t_tach();
      t_range();
      summarize();
   end
endmodule
